// ---- rtl/csr_shift_reg.sv ----
// configurable shift register with parallel load and axi4-lite setup
// How it works
// - direction pin level equal to direction polarity shifts left, else right
// - load pin level equal to load polarity loads word, else shifts
// - set and reset pins active high when polarity is one, else low
// - edge select zero uses rising clock pin edge, one falling
// - async reset gives async clear value, sync reset gives sync clear value
// - async set gives async preset value, sync set gives sync preset value
// - output starts at power-on value before any edge, set or reset
// - parallel word width fixed by word width constant
`timescale 1ns/100ps
module csr_shift_reg
    import csr_pkg::*;
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [csr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [csr_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic [csr_pkg::WORD_W-1:0] par_data,
    input  wire logic                       dev_clk,
    input  wire logic                       load_shift,
    input  wire logic                       direction,
    input  wire logic                       serial_in,
    input  wire logic                       async_set,
    input  wire logic                       async_reset,
    input  wire logic                       sync_set,
    input  wire logic                       sync_reset,
    output logic [csr_pkg::WORD_W-1:0]      word_out
);
    logic [PIN_W-1:0]  pins_s;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [WORD_W-1:0] aclr_q, aclr_d, sclr_q, sclr_d, apre_q, apre_d, spre_q, spre_d;
    logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0]       wdata_q, wdata_d;
    logic              wlane_q, wlane_d;
    logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              do_write;
    logic [WORD_W-1:0] sreg_q, sreg_d;
    logic              clk_prev_q, clk_prev_d;
    logic              clk_s, trig, arst_act, aset_act, srst_act, sset_act;
    logic              load_go, shift_go, go_left;
    logic [WORD_W-1:0] din_s, shl_val, shr_val;

    // pins cross in through two flops before use
    csr_sync2 u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pins_in   ({serial_in, sync_reset, sync_set, async_reset, async_set, direction, load_shift, dev_clk,
                     par_data}),
        .pins_sync (pins_s)
    );

    assign din_s   = pins_s[WORD_W-1:0];
    assign clk_s   = pins_s[PIN_CLK];
    assign shl_val = {sreg_q[WORD_W-2:0], pins_s[PIN_SER]};
    assign shr_val = {pins_s[PIN_SER], sreg_q[WORD_W-1:1]};

    assign trig = (ctrl_q[CTRL_EDGE] == EDGE_1_TO_0) ? (clk_prev_q & ~clk_s) : (~clk_prev_q & clk_s);
    assign arst_act = ~(pins_s[PIN_ARST] ^ ctrl_q[CTRL_SR]);
    assign aset_act = ~(pins_s[PIN_ASET] ^ ctrl_q[CTRL_SR]);
    assign srst_act = ~(pins_s[PIN_SRST] ^ ctrl_q[CTRL_SR]);
    assign sset_act = ~(pins_s[PIN_SSET] ^ ctrl_q[CTRL_SR]);
    assign load_go  = trig & ~arst_act & ~aset_act & ~srst_act & ~sset_act & (pins_s[PIN_LOAD] == ctrl_q[CTRL_LOAD]);
    assign shift_go = trig & ~arst_act & ~aset_act & ~srst_act & ~sset_act & (pins_s[PIN_LOAD] != ctrl_q[CTRL_LOAD]);
    assign go_left  = (pins_s[PIN_DIR] == ctrl_q[CTRL_DIR]);

    // word next value; async beats sync, and within each clear beats preset
    always_comb
    begin
        clk_prev_d = clk_s;
        sreg_d     = sreg_q;
        if (arst_act)
            sreg_d = aclr_q; // async clear
        else if (aset_act)
            sreg_d = apre_q; // async preset
        else if (trig && srst_act)
            sreg_d = sclr_q; // sync clear
        else if (trig && sset_act)
            sreg_d = spre_q; // sync preset
        else if (load_go)
            sreg_d = din_s;
        else if (shift_go)
            sreg_d = go_left ? shl_val : shr_val;
        if (!aresetn)
        begin
            sreg_d     = POWER_ON_OUTPUT;
            clk_prev_d = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        sreg_q     <= sreg_d;
        clk_prev_q <= clk_prev_d;
    end

    assign word_out = sreg_q;

    // write fires once both halves are held and no response is pending
    assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;

    // bus slave next values
    always_comb
    begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wlane_d   = wlane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        ctrl_d    = ctrl_q;
        aclr_d    = aclr_q;
        sclr_d    = sclr_q;
        apre_d    = apre_q;
        spre_d    = spre_q;
        if (s_axi_awvalid && !aw_hold_q)
        begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_q)
        begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wlane_d  = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            bvalid_d = 1'b0;
        if (do_write)
        begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            // every field sits in byte lane 0
            case (awaddr_q)
                OFS_CTRL: if (wlane_q) ctrl_d = wdata_q[CTRL_W-1:0];
                OFS_ACLR: if (wlane_q) aclr_d = wdata_q[WORD_W-1:0];
                OFS_SCLR: if (wlane_q) sclr_d = wdata_q[WORD_W-1:0];
                OFS_APRE: if (wlane_q) apre_d = wdata_q[WORD_W-1:0];
                OFS_SPRE: if (wlane_q) spre_d = wdata_q[WORD_W-1:0];
                OFS_WORD: bresp_d = RESP_OKAY; // read-only, write dropped
                default:  bresp_d = RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
                OFS_ACLR: rdata_d[WORD_W-1:0] = aclr_q;
                OFS_SCLR: rdata_d[WORD_W-1:0] = sclr_q;
                OFS_APRE: rdata_d[WORD_W-1:0] = apre_q;
                OFS_SPRE: rdata_d[WORD_W-1:0] = spre_q;
                OFS_WORD: rdata_d[WORD_W-1:0] = sreg_q;
                default:  rresp_d = RESP_SLVERR;
            endcase
        end
        if (!aresetn)
        begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            awaddr_d  = 8'h00;
            wdata_d   = 32'h0000_0000;
            wlane_d   = 1'b0;
            bvalid_d  = 1'b0;
            bresp_d   = RESP_OKAY;
            rvalid_d  = 1'b0;
            rresp_d   = RESP_OKAY;
            rdata_d   = 32'h0000_0000;
            ctrl_d    = CTRL_RST;
            aclr_d    = ACLR_RST;
            sclr_d    = SCLR_RST;
            apre_d    = APRE_RST;
            spre_d    = SPRE_RST;
        end
    end

    // bus slave registers
    always_ff @(posedge aclk)
    begin
        aw_hold_q <= aw_hold_d;
        w_hold_q  <= w_hold_d;
        awaddr_q  <= awaddr_d;
        wdata_q   <= wdata_d;
        wlane_q   <= wlane_d;
        bvalid_q  <= bvalid_d;
        bresp_q   <= bresp_d;
        rvalid_q  <= rvalid_d;
        rresp_q   <= rresp_d;
        rdata_q   <= rdata_d;
        ctrl_q    <= ctrl_d;
        aclr_q    <= aclr_d;
        sclr_q    <= sclr_d;
        apre_q    <= apre_d;
        spre_q    <= spre_d;
    end

    assign s_axi_awready = ~aw_hold_q;
    assign s_axi_wready  = ~w_hold_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // checks on the word path
    property p_shift_left;
        @(posedge aclk) disable iff (!aresetn) shift_go && go_left |=> sreg_q == $past(shl_val);
    endproperty
    a_shift_left: assert property (p_shift_left) else $error("left shift wrong");
    property p_shift_right;
        @(posedge aclk) disable iff (!aresetn) shift_go && !go_left |=> sreg_q == $past(shr_val);
    endproperty
    a_shift_right: assert property (p_shift_right) else $error("right shift wrong");
    property p_load;
        @(posedge aclk) disable iff (!aresetn)
            trig && !arst_act && !aset_act && !srst_act && !sset_act
            && pins_s[PIN_LOAD] == ctrl_q[CTRL_LOAD] |=> sreg_q == $past(din_s);
    endproperty
    a_load: assert property (p_load) else $error("parallel load wrong");
    property p_sr_level;
        @(posedge aclk) disable iff (!aresetn) (pins_s[PIN_ARST] == ctrl_q[CTRL_SR]) |=> sreg_q == $past(aclr_q);
    endproperty
    a_sr_level: assert property (p_sr_level) else $error("reset level wrong");
    property p_edge;
        @(posedge aclk) disable iff (!aresetn)
            ctrl_q[CTRL_EDGE] == EDGE_0_TO_1 && $rose(clk_s) |-> trig;
    endproperty
    a_edge: assert property (p_edge) else $error("rising edge missed");
    property p_sync_clr;
        @(posedge aclk) disable iff (!aresetn) trig && srst_act && !arst_act && !aset_act |=> sreg_q == $past(sclr_q);
    endproperty
    a_sync_clr: assert property (p_sync_clr) else $error("sync clear wrong");
    property p_sync_set;
        @(posedge aclk) disable iff (!aresetn)
            trig && sset_act && !srst_act && !arst_act && !aset_act |=> sreg_q == $past(spre_q);
    endproperty
    a_sync_set: assert property (p_sync_set) else $error("sync preset wrong");
    property p_power_on;
        @(posedge aclk) $rose(aresetn) |-> sreg_q == POWER_ON_OUTPUT;
    endproperty
    a_power_on: assert property (p_power_on) else $error("power-on value wrong");
    property p_async_hold;
        @(posedge aclk) disable iff (!aresetn) arst_act [*2] |-> sreg_q == $past(aclr_q);
    endproperty
    a_async_hold: assert property (p_async_hold) else $error("async clear not held");
    property p_async_set;
        @(posedge aclk) disable iff (!aresetn) aset_act && !arst_act |=> sreg_q == $past(apre_q);
    endproperty
    a_async_set: assert property (p_async_set) else $error("async preset wrong");
endmodule : csr_shift_reg

// ---- rtl/csr_pkg.sv ----
// shared constants for the configurable shift register
package csr_pkg;
    localparam int unsigned WORD_W      = 8;
    localparam int unsigned PIN_W       = WORD_W + 8;
    localparam int unsigned ADDR_W      = 8;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_ACLR    = 8'h04;
    localparam logic [7:0]  OFS_SCLR    = 8'h08;
    localparam logic [7:0]  OFS_APRE    = 8'h0C;
    localparam logic [7:0]  OFS_SPRE    = 8'h10;
    localparam logic [7:0]  OFS_WORD    = 8'h14;
    // control field positions
    localparam int unsigned CTRL_DIR    = 0;
    localparam int unsigned CTRL_LOAD   = 1;
    localparam int unsigned CTRL_SR     = 2;
    localparam int unsigned CTRL_EDGE   = 3;
    localparam int unsigned CTRL_W      = 4;
    // edge select encodings
    localparam logic        EDGE_0_TO_1 = 1'b0;
    localparam logic        EDGE_1_TO_0 = 1'b1;
    // reset values
    localparam logic [3:0]  CTRL_RST    = 4'h7;
    localparam logic [7:0]  ACLR_RST    = 8'h00;
    localparam logic [7:0]  SCLR_RST    = 8'h00;
    localparam logic [7:0]  APRE_RST    = 8'hFF;
    localparam logic [7:0]  SPRE_RST    = 8'hFF;
    localparam logic [7:0]  POWER_ON_OUTPUT = 8'h00;
    // pin vector layout inside the synchroniser
    localparam int unsigned PIN_CLK     = WORD_W + 0;
    localparam int unsigned PIN_LOAD    = WORD_W + 1;
    localparam int unsigned PIN_DIR     = WORD_W + 2;
    localparam int unsigned PIN_ASET    = WORD_W + 3;
    localparam int unsigned PIN_ARST    = WORD_W + 4;
    localparam int unsigned PIN_SSET    = WORD_W + 5;
    localparam int unsigned PIN_SRST    = WORD_W + 6;
    localparam int unsigned PIN_SER     = WORD_W + 7;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : csr_pkg

// ---- rtl/csr_sync2.sv ----
// two-stage synchroniser for all device pins
`timescale 1ns/100ps
module csr_sync2
    import csr_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [PIN_W-1:0]   pins_in,
    output logic      [PIN_W-1:0]   pins_sync
);
    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] meta_d;
    logic [PIN_W-1:0] sync_q;
    logic [PIN_W-1:0] sync_d;

    // first stage feeds only the second
    always_comb
    begin
        meta_d = aresetn ? pins_in : {PIN_W{1'b0}};
        sync_d = aresetn ? meta_q : {PIN_W{1'b0}};
    end

    always_ff @(posedge aclk)
    begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign pins_sync = sync_q;
endmodule : csr_sync2

// ---- verification/csr_pin_model.sv ----
// far-side logic model that drives the device clock pin
`timescale 1ns/100ps
module csr_pin_model
(
    input  wire logic aclk,
    output logic      dev_clk
);
    // pin rests low between frames, so no stray edge reaches the register
    initial dev_clk = 1'b0;

    // one level held for hold aclk cycles; a hold of 0 never reaches the synchroniser
    task automatic drive(input logic v, input int hold);
        dev_clk <= v;
        repeat (hold) @(posedge aclk);
    endtask : drive

    // full pin period, the low tail gives the register time to settle
    task automatic pulse(input int hold);
        drive(1'b1, hold);
        drive(1'b0, hold + 1);
    endtask : pulse
endmodule : csr_pin_model

// ---- verification/configurable_shift_register_tb_top.sv ----
// self-checking bench for the configurable shift register
`timescale 1ns/100ps
module configurable_shift_register_tb_top;
    import csr_pkg::*;
    logic              aclk = 1'b0;
    logic              aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_rready;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [WORD_W-1:0] par_data, word_out;
    logic              dev_clk, load_shift, direction, serial_in;
    logic              async_set, async_reset, sync_set, sync_reset;
    int                num_errors = 0, n_tests = 0, cyc = 0;
    localparam logic [7:0]  RD_OFS [7] = '{OFS_CTRL, OFS_ACLR, OFS_SCLR, OFS_APRE, OFS_SPRE, OFS_WORD, 8'h18};
    localparam logic [31:0] RD_EXP [7] = '{32'h7, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0};

    csr_shift_reg DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .par_data, .dev_clk, .load_shift, .direction, .serial_in, .async_set,
        .async_reset, .sync_set, .sync_reset, .word_out);
    csr_pin_model far (.aclk, .dev_clk);

    // 50 MHz system clock
    always #10 aclk = ~aclk;

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p)
        begin
            @(posedge aclk);
            if (aw_p && s_axi_awready === 1'b1)
            begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready === 1'b1)
            begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        // bready stays high, so a second call never toggles it in one step
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er, "bresp");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        // rready stays high between reads
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, ed, "rdata");
        chk(s_axi_rresp, er, "rresp");
    endtask : rd

    // pins as {load, dir, serial, aset, areset, sset, sreset}; 4 cycles covers sync latency
    task automatic setp(input logic [6:0] v);
        {load_shift, direction, serial_in, async_set, async_reset, sync_set, sync_reset} <= v;
        repeat (4) @(posedge aclk);
    endtask : setp

    task automatic t_regs;
        chk(word_out, POWER_ON_OUTPUT, "power-on word");
        chk($bits(word_out), WORD_W, "word width");
        for (int i = 0; i < 7; i++)
            rd(RD_OFS[i], RD_EXP[i], (i == 6) ? RESP_SLVERR : RESP_OKAY);
        wr(OFS_WORD, 32'h5A, RESP_OKAY);
        rd(OFS_WORD, 32'h0, RESP_OKAY);
        wr(8'h18, 32'h1, RESP_SLVERR);
        // lane 0 strobe off: the write must be dropped
        s_axi_wstrb <= 4'hE;
        wr(OFS_ACLR, 32'h33, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(OFS_ACLR, 32'h0, RESP_OKAY);
        $display("test regs done");
    endtask : t_regs

    task automatic t_shift;
        par_data <= 8'hA5;
        setp(7'b1000000);
        far.pulse(3);
        chk(word_out, 8'hA5, "load high");
        setp(7'b0110000);
        far.pulse(3);
        chk(word_out, 8'h4B, "left on high");
        setp(7'b0000000);
        far.pulse(3);
        chk(word_out, 8'h25, "right on low");
        $display("test shift done");
    endtask : t_shift

    task automatic t_pol;
        wr(OFS_CTRL, 32'h4, RESP_OKAY);
        par_data <= 8'h3C;
        setp(7'b0000000);
        far.pulse(4);
        chk(word_out, 8'h3C, "load low");
        setp(7'b1000000);
        far.pulse(4);
        chk(word_out, 8'h78, "left on low");
        setp(7'b1100000);
        far.pulse(4);
        chk(word_out, 8'h3C, "right on high");
        $display("test polarity done");
    endtask : t_pol

    task automatic t_sync;
        wr(OFS_CTRL, 32'h7, RESP_OKAY);
        wr(OFS_SCLR, 32'h5A, RESP_OKAY);
        wr(OFS_SPRE, 32'hA5, RESP_OKAY);
        setp(7'b0000010);
        chk(word_out, 8'h3C, "sync set waits for edge");
        far.pulse(3);
        chk(word_out, 8'hA5, "sync preset");
        setp(7'b0000011);
        far.pulse(3);
        chk(word_out, 8'h5A, "sync clear");
        setp(7'b0000000);
        $display("test sync done");
    endtask : t_sync

    task automatic t_async;
        wr(OFS_ACLR, 32'h81, RESP_OKAY);
        wr(OFS_APRE, 32'h7E, RESP_OKAY);
        setp(7'b0001000);
        chk(word_out, 8'h7E, "async preset");
        setp(7'b0001100);
        chk(word_out, 8'h81, "async clear");
        par_data <= 8'hFF;
        setp(7'b1001111);
        far.pulse(3);
        chk(word_out, 8'h81, "async overrides load");
        // pins now idle high, so low polarity releases them all
        wr(OFS_CTRL, 32'h3, RESP_OKAY);
        far.pulse(3);
        chk(word_out, 8'hFF, "high pins inactive");
        setp(7'b1000111);
        chk(word_out, 8'h7E, "async set active low");
        setp(7'b1001111);
        wr(OFS_CTRL, 32'h7, RESP_OKAY);
        setp(7'b0000000);
        chk(word_out, 8'h81, "async clear back high");
        $display("test async done");
    endtask : t_async

    task automatic t_edge;
        wr(OFS_CTRL, 32'hF, RESP_OKAY);
        par_data <= 8'hC3;
        setp(7'b1000000);
        far.drive(1'b1, 6);
        chk(word_out, 8'h81, "rising ignored");
        far.drive(1'b0, 6);
        chk(word_out, 8'hC3, "falling loads");
        $display("test edge done");
    endtask : t_edge

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // reset for 8 cycles, then the scenarios in turn
    initial
    begin
        aresetn       <= 1'b0;
        s_axi_awaddr  <= 8'h00;
        s_axi_araddr  <= 8'h00;
        s_axi_wdata   <= 32'h0000_0000;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b0;
        par_data      <= 8'h00;
        {load_shift, direction, serial_in, async_set, async_reset, sync_set, sync_reset} <= 7'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_shift();
        t_pol();
        t_sync();
        t_async();
        t_edge();
        test_done();
    end
endmodule : configurable_shift_register_tb_top
